// *** src/dja_params.svh ***
// Purpose: Constants of the de-sync jitter attenuator control block
// Assumes: APB byte address is four times the register index
// Notes: Summary of operation follows
//
// Summary of operation
// - One 8-bit control register per channel at 0x07/0x0F/0x17, top three bits read zero.
// - Host mode: bit0=1 and bit2=0 selects very narrow de-sync bandwidth.
// - Path bit1 (or path pin) high puts attenuator in transmit path, else receive.
// - Recovery-disable bit4 low runs fast recovery, reacquiring within 50 ms.
// - Hardware mode keeps fast recovery always on; only register bit disables it.
// - Gapped clock with up to 59 missing pulses is accepted unprocessed.
// - Each data bit latched on gapped clock edge, then smoothed before line output unless bits 0 and 2 (or the two bandwidth pins) are both low (bypass).
`ifndef DJA_PARAMS_SVH
`define DJA_PARAMS_SVH

`define DJA_CTRL0_IDX      8'h07
`define DJA_CTRL1_IDX      8'h0f
`define DJA_CTRL2_IDX      8'h17
`define DJA_STATUS_IDX     8'h20
`define DJA_CTRL_RESET     8'h00
`define DJA_BW_LOW_BIT     0
`define DJA_PATH_BIT       1
`define DJA_BW_HIGH_BIT    2
`define DJA_RESTART_BIT    3
`define DJA_FAST_DIS_BIT   4
`define DJA_CTRL_WMASK     8'h1f
`define DJA_STAT_SLIP_LSB  4
`define DJA_PCLK_HZ        25000000
`define DJA_DS3_HZ         44736000
`define DJA_FAST_REC_MS    50
`define DJA_SLOW_REC_MS    100
`define DJA_NARROW_SHIFT   2
`define DJA_WIDE_SHIFT     5

`endif

// *** src/dja_pkg.sv ***
// Purpose: Types shared by the jitter attenuator control block
// Assumes: Used with dja_params.svh
// Notes: Recovery states are Gray coded along acquire, track, hold
package dja_pkg;
  typedef enum logic [1:0]
  {
    DJA_ACQUIRE = 2'b00,
    DJA_TRACK   = 2'b01,
    DJA_HOLD    = 2'b11
  } dja_rec_state_t;
  typedef logic [7:0] dja_byte_t;
endpackage

// *** src/dja_link_if.sv ***
// Purpose: Carrier between link-clock capture and pclk attenuator core
// Assumes: word is stable while toggle is unchanged
// Notes: restart_n is a level from the pclk side
`timescale 1ns/100ps
interface dja_link_if;
  logic [7:0] word;
  logic       word_tgl;
  logic       restart_n;
  modport link
  (
    output word,
    output word_tgl,
    input  restart_n
  );
  modport core
  (
    input  word,
    input  word_tgl,
    output restart_n
  );
endinterface

// *** src/dja_link_capture.sv ***
// Purpose: Latch gapped serial data on the gapped clock and pack bytes
// Assumes: Link clock may stop at any time between pulses
// Notes: Nothing here times the gaps between clock edges, so gaps of any length are harmless
`timescale 1ns/100ps
module dja_link_capture
(
  input  wire logic tx_gapped_clock_in,
  input  wire logic presetn,
  input  wire logic tx_serial_data_in,
  dja_link_if.link  lnk
);
  logic       rst_sync1_ff;
  logic       rst_sync2_ff;
  logic       rs_sync1_ff;
  logic       rs_sync2_ff;
  logic [6:0] shift_ff;
  logic [2:0] cnt_ff;
  logic [7:0] word_ff;
  logic       tgl_ff;
  wire        run;
  wire        byte_done;

  // Reset release is synchronised to the link clock
  always_ff @(posedge tx_gapped_clock_in or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  always_ff @(posedge tx_gapped_clock_in or negedge presetn)
  begin
    if (!presetn)
    begin
      rs_sync1_ff <= 1'b0;
      rs_sync2_ff <= 1'b0;
    end
    else
    begin
      rs_sync1_ff <= lnk.restart_n;
      rs_sync2_ff <= rs_sync1_ff;
    end
  end

  assign run       = rst_sync2_ff & rs_sync2_ff;
  assign byte_done = (cnt_ff == 3'h7);

  // Every rising edge of the gapped clock while run is high latches one data bit
  always_ff @(posedge tx_gapped_clock_in or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_ff <= 7'h00;
      cnt_ff   <= 3'h0;
      word_ff  <= 8'h00;
      tgl_ff   <= 1'b0;
    end
    else if (!run)
    begin
      shift_ff <= 7'h00;
      cnt_ff   <= 3'h0;
    end
    else
    begin
      shift_ff <= {shift_ff[5:0], tx_serial_data_in};
      cnt_ff   <= cnt_ff + 3'h1;
      if (byte_done)
      begin
        word_ff <= {shift_ff, tx_serial_data_in};
        tgl_ff  <= ~tgl_ff;
      end
    end
  end

  assign lnk.word     = word_ff;
  assign lnk.word_tgl = tgl_ff;
endmodule

// *** src/dja_desync_atten.sv ***
// Purpose: Per-channel jitter attenuator control with APB registers and smoothing core
// Assumes: APB master per AMBA; no wait states, pready is high in the first access cycle
// Notes: Smoothed output is byte wide since pclk is slower than the DS3 bit rate
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "dja_params.svh"
module dja_desync_atten
#(
  parameter int          CH            = 3,
  parameter int          DEPTH         = 8,
  parameter int unsigned FAST_REC_CYC  = `DJA_FAST_REC_MS * (`DJA_PCLK_HZ / 1000),
  parameter int unsigned SLOW_HOLD_CYC = `DJA_SLOW_REC_MS * (`DJA_PCLK_HZ / 1000)
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            host_mode,
  input  wire logic [CH-1:0]   atten_bw_sel_low,
  input  wire logic [CH-1:0]   atten_bw_sel_high,
  input  wire logic [CH-1:0]   atten_path_select,
  input  wire logic [CH-1:0]   tx_gapped_clock_in,
  input  wire logic [CH-1:0]   tx_serial_data_in,
  output logic      [CH*8-1:0] line_word,
  output logic      [CH-1:0]   line_word_valid,
  output logic      [CH-1:0]   atten_in_tx_path,
  output logic      [CH-1:0]   atten_narrow_bw,
  output logic      [CH-1:0]   fast_recovery_on
);
  localparam int              PW         = $clog2(DEPTH);
  localparam logic [PW:0]     HALF       = (PW+1)'(DEPTH / 2);
  localparam logic [PW:0]     FULL       = (PW+1)'(DEPTH);
  localparam longint          STEP_L     = (64'd`DJA_DS3_HZ * 64'd65536) / (64'd8 * 64'd`DJA_PCLK_HZ);
  localparam logic [16:0]     NCO_STEP   = 17'(STEP_L);
  localparam logic [7:0]      STAT_IDX   = `DJA_STATUS_IDX;
  localparam logic [7:0]      CTRL_IDX [3] = '{`DJA_CTRL0_IDX, `DJA_CTRL1_IDX, `DJA_CTRL2_IDX};
  localparam int unsigned     FAST_TRY   = FAST_REC_CYC;

  logic [2:0]    mode_sync_ff;
  logic [CH-1:0] bwl_s1_ff;
  logic [CH-1:0] bwl_s2_ff;
  logic [CH-1:0] bwh_s1_ff;
  logic [CH-1:0] bwh_s2_ff;
  logic [CH-1:0] pth_s1_ff;
  logic [CH-1:0] pth_s2_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic [31:0]   prdata_ff;
  logic [CH-1:0] slip_ff;
  logic [7:0]    ctrl_rd [CH];
  logic [CH-1:0] ctrl_hit;
  logic [CH-1:0] slip_evt;
  logic [CH-1:0] active;

  wire           setup_ph   = psel & ~penable;
  wire           wr_fire    = psel & penable & pready_ff & pwrite;
  wire           host_sel   = mode_sync_ff[1];
  wire           stat_hit   = (paddr == {STAT_IDX[5:0], 2'b00});
  wire           addr_ok    = stat_hit | (|ctrl_hit);
  wire           stat_wr    = wr_fire & stat_hit;
  wire [31:0]    stat_word  = {24'h000000, 1'b0, slip_ff, 1'b0, active};

  // Hardware-mode pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_sync_ff <= 3'h0;
      bwl_s1_ff    <= '0;
      bwl_s2_ff    <= '0;
      bwh_s1_ff    <= '0;
      bwh_s2_ff    <= '0;
      pth_s1_ff    <= '0;
      pth_s2_ff    <= '0;
    end
    else
    begin
      mode_sync_ff <= {1'b0, mode_sync_ff[0], host_mode};
      bwl_s1_ff    <= atten_bw_sel_low;
      bwl_s2_ff    <= bwl_s1_ff;
      bwh_s1_ff    <= atten_bw_sel_high;
      bwh_s2_ff    <= bwh_s1_ff;
      pth_s1_ff    <= atten_path_select;
      pth_s2_ff    <= pth_s1_ff;
    end
  end

  // Read data is captured in setup so the answer comes from a flop
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = stat_hit ? stat_word : 32'h00000000;
    for (int i = 0; i < CH; i++)
    begin
      if (ctrl_hit[i])
      begin
        rd_mux = {24'h000000, ctrl_rd[i]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setup_ph;
      pslverr_ff <= setup_ph & ~addr_ok;
      prdata_ff  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Slip flags: write one clears, a new slip in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slip_ff <= '0;
    end
    else
    begin
      slip_ff <= slip_evt | (slip_ff & ~(stat_wr ? pwdata[`DJA_STAT_SLIP_LSB +: CH] : {CH{1'b0}}));
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  for (genvar c = 0; c < CH; c++)
  begin : g_ch
    dja_link_if lnk ();

    dja_link_capture u_cap
    (
      .tx_gapped_clock_in (tx_gapped_clock_in[c]),
      .presetn            (presetn),
      .tx_serial_data_in  (tx_serial_data_in[c]),
      .lnk                (lnk.link)
    );

    logic [4:0]                 ctrl_ff;
    logic [2:0]                 tgl_sync_ff;
    dja_pkg::dja_byte_t         store_ff [DEPTH];
    logic [PW-1:0]              wp_ff;
    logic [PW-1:0]              rp_ff;
    logic [PW:0]                fill_ff;
    logic [15:0]                acc_ff;
    dja_pkg::dja_rec_state_t    st_ff;
    logic [31:0]                hold_ff;
    logic [7:0]                 out_ff;
    logic                       outv_ff;
    logic                       tx_ff;
    logic                       nb_ff;
    logic                       fr_ff;

    assign ctrl_hit[c] = (paddr == {CTRL_IDX[c][5:0], 2'b00});
    assign ctrl_rd[c]  = {3'h0, ctrl_ff};

    wire ctrl_wr  = wr_fire & ctrl_hit[c];
    wire restart  = host_sel & ctrl_ff[`DJA_RESTART_BIT];
    wire bw_low   = host_sel ? ctrl_ff[`DJA_BW_LOW_BIT]  : bwl_s2_ff[c];
    wire bw_high  = host_sel ? ctrl_ff[`DJA_BW_HIGH_BIT] : bwh_s2_ff[c];
    wire narrow   = bw_low & ~bw_high;
    wire bypass   = ~bw_low & ~bw_high;
    wire to_tx    = host_sel ? ctrl_ff[`DJA_PATH_BIT] : pth_s2_ff[c];
    wire fast     = ~host_sel | ~ctrl_ff[`DJA_FAST_DIS_BIT];
    wire new_word = tgl_sync_ff[2] ^ tgl_sync_ff[1];
    wire signed [PW+1:0] err = $signed({1'b0, fill_ff}) - $signed({1'b0, HALF});
    wire signed [16:0]   adj = narrow ? 17'(err <<< `DJA_NARROW_SHIFT) : 17'(err <<< `DJA_WIDE_SHIFT);
    wire [16:0]   sum      = {1'b0, acc_ff} + NCO_STEP + adj;
    wire          tick     = sum[16];
    wire          tracking = (st_ff == dja_pkg::DJA_TRACK);
    wire          rd_ok    = tracking & tick & (fill_ff != '0);
    wire          under    = tracking & tick & (fill_ff == '0);
    wire          wr_ok    = new_word & (fill_ff != FULL) & (st_ff != dja_pkg::DJA_HOLD);
    wire          over     = new_word & (fill_ff == FULL);

    assign lnk.restart_n = ~restart;
    assign slip_evt[c]   = ~bypass & (under | over);
    assign active[c]     = tracking;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ctrl_ff     <= 5'(`DJA_CTRL_RESET);
        tgl_sync_ff <= 3'h0;
      end
      else
      begin
        if (ctrl_wr)
        begin
          ctrl_ff <= pwdata[4:0] & 5'(`DJA_CTRL_WMASK);
        end
        tgl_sync_ff <= {tgl_sync_ff[1:0], lnk.word_tgl};
      end
    end

    always_ff @(posedge pclk)
    begin
      if (wr_ok)
      begin
        store_ff[wp_ff] <= lnk.word;
      end
    end

    // Elastic store drained by a fill-steered NCO; narrow mode steers gently
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        wp_ff   <= '0;
        rp_ff   <= '0;
        fill_ff <= '0;
        acc_ff  <= 16'h0000;
        st_ff   <= dja_pkg::DJA_ACQUIRE;
        hold_ff <= 32'h00000000;
        out_ff  <= 8'h00;
        outv_ff <= 1'b0;
      end
      else if (restart)
      begin
        wp_ff   <= '0;
        rp_ff   <= '0;
        fill_ff <= '0;
        acc_ff  <= 16'h0000;
        st_ff   <= dja_pkg::DJA_ACQUIRE;
        hold_ff <= 32'h00000000;
        outv_ff <= 1'b0;
      end
      else if (bypass)
      begin
        outv_ff <= new_word;
        if (new_word)
        begin
          out_ff <= lnk.word;
        end
      end
      else
      begin
        acc_ff  <= tracking ? sum[15:0] : 16'h0000;
        outv_ff <= rd_ok;
        if (rd_ok)
        begin
          out_ff <= store_ff[rp_ff];
          rp_ff  <= rp_ff + 1'b1;
        end
        if (wr_ok)
        begin
          wp_ff <= wp_ff + 1'b1;
        end
        fill_ff <= fill_ff + (PW+1)'(wr_ok) - (PW+1)'(rd_ok);
        case (st_ff)
          dja_pkg::DJA_ACQUIRE:
          begin
            if (fill_ff >= HALF)
            begin
              st_ff <= dja_pkg::DJA_TRACK;
            end
          end
          dja_pkg::DJA_TRACK:
          begin
            // Fast mode refills at once, far inside the 50 ms budget
            if ((under | over) & fast)
            begin
              st_ff <= dja_pkg::DJA_ACQUIRE;
            end
            else if (under | over)
            begin
              st_ff   <= dja_pkg::DJA_HOLD;
              hold_ff <= 32'h00000000;
            end
          end
          dja_pkg::DJA_HOLD:
          begin
            // Slow recovery flushes and idles before reacquiring
            rp_ff   <= wp_ff;
            fill_ff <= '0;
            hold_ff <= hold_ff + 32'h00000001;
            if (fast || hold_ff >= SLOW_HOLD_CYC - 1)
            begin
              st_ff <= dja_pkg::DJA_ACQUIRE;
            end
          end
          default:
          begin
            st_ff <= dja_pkg::DJA_ACQUIRE;
          end
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        tx_ff <= 1'b0;
        nb_ff <= 1'b0;
        fr_ff <= 1'b1;
      end
      else
      begin
        tx_ff <= to_tx;
        nb_ff <= narrow;
        fr_ff <= fast;
      end
    end

    assign line_word[c*8 +: 8] = out_ff;
    assign line_word_valid[c]  = outv_ff;
    assign atten_in_tx_path[c] = tx_ff;
    assign atten_narrow_bw[c]  = nb_ff;
    assign fast_recovery_on[c] = fr_ff;
  end
endmodule

// *** tb/dja_desync_atten_asserts.sv ***
// Purpose: Port-level checks of the attenuator control block
// Assumes: One access cycle per APB transfer
// Notes: Host-mode checks follow a shadow of channel 0 control
`timescale 1ns/100ps
module dja_desync_atten_chk
#(
  parameter int CH = 3
)
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          host_mode,
  input wire logic [CH-1:0] line_word_valid,
  input wire logic [CH-1:0] atten_narrow_bw,
  input wire logic [CH-1:0] atten_in_tx_path,
  input wire logic [CH-1:0] fast_recovery_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] sh_ff;
  logic [3:0] quiet_ff;
  logic       host_ff;
  wire        acc     = psel && penable && pready;
  wire        ctl_adr = paddr == 8'h1c || paddr == 8'h3c || paddr == 8'h5c;
  wire        wr0     = acc && pwrite && paddr == 8'h1c;
  // Outputs pass two synchronisers, so judge them only once settled
  // A mode change is not settled in the very cycle it is first seen
  wire        settled = quiet_ff == 4'hf && host_ff == host_mode;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_ff    <= 5'h00;
      quiet_ff <= 4'h0;
      host_ff  <= 1'b0;
    end
    else
    begin
      host_ff <= host_mode;
      if (wr0)
        sh_ff <= pwdata[4:0];
      if (wr0 || host_ff != host_mode)
        quiet_ff <= 4'h0;
      else if (!settled)
        quiet_ff <= quiet_ff + 4'h1;
    end
  end
  sequence s_xfer;
    psel && !penable ##1 psel && penable;
  endsequence
  chk_one_wait: assert property (s_xfer |-> pready)
    else $error("pready missing in access cycle");
  chk_bad_addr: assert property (acc && !ctl_adr && paddr != 8'h80 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_top_zero: assert property (acc && ctl_adr && !pwrite |-> prdata[31:5] == 27'h0 && !pslverr)
    else $error("control read shows unused bits");
  chk_hw_fast: assert property (!host_mode && settled |-> &fast_recovery_on)
    else $error("fast recovery off in hardware mode");
  chk_host_fast: assert property (host_mode && settled |-> fast_recovery_on[0] == !sh_ff[4])
    else $error("fast recovery not following its bit");
  chk_host_narrow: assert property (host_mode && settled |-> atten_narrow_bw[0] == (sh_ff[0] && !sh_ff[2]))
    else $error("narrow bandwidth wrong");
  chk_host_path: assert property (host_mode && settled |-> atten_in_tx_path[0] == sh_ff[1])
    else $error("path select wrong");
  chk_restart_hold: assert property (host_mode && settled && sh_ff[3] |-> !line_word_valid[0])
    else $error("byte delivered during restart");
endmodule
bind dja_desync_atten dja_desync_atten_chk #(.CH(CH)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .host_mode(host_mode), .line_word_valid(line_word_valid), .atten_narrow_bw(atten_narrow_bw),
  .atten_in_tx_path(atten_in_tx_path), .fast_recovery_on(fast_recovery_on)
);

// *** tb/dja_mapper_model.sv ***
// Purpose: Mapper-side source of gapped clock and data
// Assumes: Data changes while the clock is low
// Notes: Sends a byte counter MSB first in the super pattern
`timescale 1ns/100ps
module dja_mapper_model
(
  input  wire logic en,
  output logic      gclk,
  output logic      sdata
);
  logic [7:0] byte_q;
  int         bit_n;
  // Clock stands still while en is low, so any gap length can be made
  task automatic burst(input int n, input bit gap);
    wait (en);
    repeat (n)
    begin
      sdata = byte_q[7 - bit_n];
      #15 gclk = 1'b1;
      #15 gclk = 1'b0;
      bit_n = (bit_n + 1) % 8;
      if (bit_n == 0)
        byte_q = byte_q + 8'h01;
    end
    sdata = ~sdata;
    if (gap)
      #30;
  endtask
  initial
  begin
    gclk   = 1'b0;
    sdata  = 1'b0;
    byte_q = 8'h00;
    bit_n  = 0;
    // Two warm-up pulses let the capture side leave its reset; they carry no data
    wait (en);
    repeat (2)
    begin
      #15 gclk = 1'b1;
      #15 gclk = 1'b0;
    end
    forever
      for (int m = 0; m < 3; m++)
      begin
        repeat (63)
          burst(7, 1'b1);
        repeat (m == 2 ? 35 : 36)
          burst(5, 1'b1);
        if (m == 2)
          burst(6, 1'b0);
      end
  end
endmodule

// *** tb/dja_desync_atten_tb.sv ***
// Purpose: Self-checking bench of the attenuator control block
// Assumes: One mapper model feeds all three channels
// Notes: Channel 1 runs through the smoothing store; it underruns but keeps byte order
`timescale 1ns/100ps
module dja_desync_atten_tb;
  logic        pclk, presetn, psel, penable, pwrite, host_mode, en, mon_on, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, gclk, sdata;
  logic [2:0]  bw_lo, bw_hi, path, lw_valid, narrow, tx_path, fast;
  logic [23:0] lw;
  logic [7:0]  exp_b [3];
  logic [7:0]  adr [3] = '{8'h1c, 8'h3c, 8'h5c};
  int          cnt [3];
  int          mismatches, checks, cyc;
  dja_desync_atten #(.SLOW_HOLD_CYC(20)) u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_mode(host_mode), .atten_bw_sel_low(bw_lo), .atten_bw_sel_high(bw_hi),
    .atten_path_select(path), .tx_gapped_clock_in({3{gclk}}), .tx_serial_data_in({3{sdata}}),
    .line_word(lw), .line_word_valid(lw_valid), .atten_in_tx_path(tx_path),
    .atten_narrow_bw(narrow), .fast_recovery_on(fast)
  );
  dja_mapper_model u_map (.en(en), .gclk(gclk), .sdata(sdata));
  task automatic give_verdict;
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      give_verdict;
    end
    for (int c = 0; c < 3; c++)
      if (lw_valid[c] === 1'b1)
      begin
        cnt[c]++;
        if (mon_on)
          check("line byte", lw[8*c +: 8], exp_b[c]);
        exp_b[c]++;
      end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, en, mon_on} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_mode = 1'b0;
    bw_lo = 3'b101;
    bw_hi = 3'b100;
    path = 3'b011;
    exp_b = '{8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check("hw narrow", narrow, 3'b001);
    check("hw path", tx_path, 3'b011);
    check("hw fast", fast, 3'b111);
    host_mode <= 1'b1;
    repeat (10) @(posedge pclk);
    check("host path", tx_path, 3'b000);
    for (int c = 0; c < 3; c++)
    begin
      apb(1'b0, adr[c], 32'h0);
      check("ctrl reset", rd_q, 32'h0);
      apb(1'b1, adr[c], 32'hffffffff);
      apb(1'b0, adr[c], 32'h0);
      check("ctrl rw", rd_q, 32'h1f);
    end
    repeat (6) @(posedge pclk);
    check("fast off", fast, 3'b000);
    check("path tx", tx_path, 3'b111);
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, adr[0], {29'h0, v[1], 1'b0, v[0]});
      repeat (6) @(posedge pclk);
      check("bw code", narrow[0], v == 1);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("bad err", err_q, 1'b1);
    check("bad data", rd_q, 32'h0);
    for (int c = 0; c < 3; c++)
      apb(1'b1, adr[c], c == 1 ? 32'h03 : 32'h0);
    mon_on = 1'b1;
    en <= 1'b1;
    repeat (300) @(posedge pclk);
    en <= 1'b0;
    repeat (60) @(posedge pclk);
    en <= 1'b1;
    repeat (300) @(posedge pclk);
    check("bytes rx", exp_b[1] > 8'd60, 1'b1);
    // The bench link is slower than the drain rate, so only the smoothed channel slips
    apb(1'b0, 8'h80, 32'h0);
    check("slip flags", rd_q[6:4], 3'b010);
    mon_on = 1'b0;
    apb(1'b1, adr[0], 32'h08);
    repeat (20) @(posedge pclk);
    cnt = '{0, 0, 0};
    repeat (100) @(posedge pclk);
    check("held", cnt[0], 0);
    apb(1'b1, adr[0], 32'h0);
    repeat (100) @(posedge pclk);
    check("resume", cnt[0] > 2, 1);
    apb(1'b1, adr[0], 32'h10);
    host_mode <= 1'b0;
    repeat (8) @(posedge pclk);
    check("hw fast on", fast, 3'b111);
    give_verdict;
  end
endmodule
